// file: shared/pw_trig_pkg.sv
// Shared constants and types for the pulse width trigger qualifier.
// Assumes a single 10 MHz clock; all times are converted to cycle counts.
package pw_trig_pkg;

   // Clock rate and period.
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned CLK_PERIOD_PS = 100_000;

   // Programmable width span, as times and as cycle counts.
   localparam int unsigned PW_MIN_PS = 33_000;
   localparam int unsigned PW_MAX_S = 10;
   localparam int unsigned PW_MIN_RAW =
      (PW_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned PW_MIN_CYC = (PW_MIN_RAW < 1) ? 1 : PW_MIN_RAW;
   localparam int unsigned PW_MAX_CYC = PW_MAX_S * CLK_HZ;

   // Guard band and resolution figures.
   localparam int unsigned GUARD_LO_PS = 16_500;
   localparam int unsigned GUARD_HI_PS = 33_000;
   localparam int unsigned NE_BAND_LO_PS = 165_000;
   localparam int unsigned NE_BAND_HI_PS = 330_000;
   localparam int unsigned RES_DIVISOR = 1000;
   localparam int unsigned GUARD_LO_RAW = GUARD_LO_PS / CLK_PERIOD_PS;
   localparam int unsigned GUARD_LO_CYC = (GUARD_LO_RAW < 1) ? 1 : GUARD_LO_RAW;
   localparam int unsigned GUARD_HI_RAW = GUARD_HI_PS / CLK_PERIOD_PS;
   localparam int unsigned GUARD_HI_CYC = (GUARD_HI_RAW < 1) ? 1 : GUARD_HI_RAW;
   localparam int unsigned NE_BAND_LO_CYC = NE_BAND_LO_PS / CLK_PERIOD_PS;
   localparam int unsigned NE_BAND_HI_CYC = NE_BAND_HI_PS / CLK_PERIOD_PS;

   // Frequency counter gate window.
   localparam int unsigned GATE_MS = 250;
   localparam int unsigned GATE_CYC = GATE_MS * (CLK_HZ / 1000);

   // Widths.
   localparam int unsigned WIDTH_W = 27;
   localparam int unsigned COUNT_W = 32;

   // Register byte offsets.
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_WIDTH = 4'h4;
   localparam logic [3:0] OFS_FREQ = 4'h8;
   localparam logic [3:0] OFS_STATUS = 4'hC;

   // Reset values.
   localparam logic [31:0] RST_CTRL = 32'h0000_0000;
   localparam logic [26:0] RST_WIDTH = 27'h000_0001;

   // Trigger type field codes.
   localparam logic [1:0] TRIG_EDGE = 2'h0;
   localparam logic [1:0] TRIG_PULSE = 2'h1;
   localparam logic [1:0] TRIG_VIDEO = 2'h2;

   // Width comparison field codes.
   localparam logic [1:0] CMP_LESS = 2'h0;
   localparam logic [1:0] CMP_GREATER = 2'h1;
   localparam logic [1:0] CMP_EQUAL = 2'h2;
   localparam logic [1:0] CMP_NOT_EQUAL = 2'h3;

   // Status bit positions.
   localparam int unsigned STAT_ACTIVE_BIT = 0;
   localparam int unsigned STAT_EVENT_BIT = 1;

   // AXI responses.
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Control register layout, bit 31 downward.
   typedef struct packed {
      logic [26:0] spare;
      logic [1:0] cmp_mode;
      logic neg_pol;
      logic [1:0] trig_type;
   } ctrl_t;

   // Measurement state.
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_PULSE = 3'b010,
      ST_FIRED = 3'b100
   } meas_state_t;

endpackage

// file: src/gate_counter.sv
// Gated event counter: counts events over a fixed window, then latches.
// Assumes events are one-cycle pulses synchronous to the clock.
`timescale 1ns/1ps
module gate_counter #(
   parameter int unsigned GATE_CYCLES = pw_trig_pkg::GATE_CYC,
   parameter int unsigned COUNT_W = pw_trig_pkg::COUNT_W
) (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Events
   input wire logic enable,
   input wire logic event_pulse,
   // Result
   output logic [COUNT_W-1:0] result_ff,
   output logic gate_done_ff
);

   logic [31:0] gate_ff;
   logic [31:0] nxt_gate;
   logic [COUNT_W-1:0] acc_ff;
   logic [COUNT_W-1:0] nxt_acc;
   logic [COUNT_W-1:0] nxt_result;
   logic nxt_gate_done;
   logic gate_end;

   // The window keeps running whatever the acquisition does.
   always_comb begin
      gate_end = (gate_ff == 32'(GATE_CYCLES - 1));
      nxt_gate = gate_end ? 32'h0000_0000 : gate_ff + 32'h0000_0001;
      nxt_acc = acc_ff;
      nxt_result = result_ff;
      nxt_gate_done = gate_end;
      if (gate_end) begin
         nxt_result = (enable && event_pulse) ? acc_ff + 1'b1 : acc_ff;
         nxt_acc = '0;
      end else if (enable && event_pulse && ~&acc_ff) begin
         nxt_acc = acc_ff + 1'b1;
      end
      if (!enable) begin
         nxt_acc = '0;
         nxt_result = '0;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         gate_ff <= 32'h0000_0000;
         acc_ff <= '0;
         result_ff <= '0;
         gate_done_ff <= 1'b0;
      end else begin
         gate_ff <= nxt_gate;
         acc_ff <= nxt_acc;
         result_ff <= nxt_result;
         gate_done_ff <= nxt_gate_done;
      end
   end

endmodule

// file: src/pulse_width_trigger.sv
// Pulse width trigger qualifier with trigger frequency counter and an
// AXI4-Lite register slave.
// Assumes the thresholded trigger source is synchronous to the clock.
`timescale 1ns/1ps
module pulse_width_trigger #(
   parameter int unsigned MAX_WIDTH_CYCLES = pw_trig_pkg::PW_MAX_CYC,
   parameter int unsigned GATE_CYCLES = pw_trig_pkg::GATE_CYC
) (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Trigger source and event
   input wire logic trig_src,
   output logic trig_event_ff,
   // AXI4-Lite write address
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [3:0] s_axi_awaddr,
   // AXI4-Lite write data
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   // AXI4-Lite write response
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // AXI4-Lite read address
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [3:0] s_axi_araddr,
   // AXI4-Lite read data
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp
);

   localparam int unsigned WW = pw_trig_pkg::WIDTH_W;

   function automatic logic [31:0] apply_strb(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = data[8*i +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic [WW-1:0] clamp_width(input logic [31:0] v);
      logic [WW-1:0] res;
      res = v[WW-1:0];
      if (v < 32'(pw_trig_pkg::PW_MIN_CYC)) begin
         res = WW'(pw_trig_pkg::PW_MIN_CYC);
      end else if (v > 32'(MAX_WIDTH_CYCLES)) begin
         res = WW'(MAX_WIDTH_CYCLES);
      end
      return res;
   endfunction

   // Register state.
   pw_trig_pkg::ctrl_t ctrl_ff;
   pw_trig_pkg::ctrl_t nxt_ctrl;
   logic [WW-1:0] width_ff;
   logic [WW-1:0] nxt_width;
   logic event_seen_ff;
   logic nxt_event_seen;

   // Bus state.
   logic aw_have_ff;
   logic nxt_aw_have;
   logic [3:0] aw_addr_ff;
   logic [3:0] nxt_aw_addr;
   logic w_have_ff;
   logic nxt_w_have;
   logic [31:0] w_data_ff;
   logic [31:0] nxt_w_data;
   logic [3:0] w_strb_ff;
   logic [3:0] nxt_w_strb;
   logic bvalid_ff;
   logic nxt_bvalid;
   logic [1:0] bresp_ff;
   logic [1:0] nxt_bresp;
   logic rvalid_ff;
   logic nxt_rvalid;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;
   logic [1:0] rresp_ff;
   logic [1:0] nxt_rresp;
   logic do_write;
   logic ev_clear;

   // Measurement state.
   pw_trig_pkg::meas_state_t state_ff;
   pw_trig_pkg::meas_state_t nxt_state;
   logic [WW-1:0] count_ff;
   logic [WW-1:0] nxt_count;
   logic prev_ff;
   logic nxt_trig_event;
   logic edge_event_ff;
   logic nxt_edge_event;

   // Comparison terms.
   logic active;
   logic lead_edge;
   logic trail_edge;
   logic [WW-1:0] tol_lo;
   logic [WW-1:0] tol_hi;
   logic [WW-1:0] lo_limit;
   logic [WW-1:0] hi_limit;

   // Frequency counter.
   logic [31:0] freq_count;
   logic count_enable;
   logic count_event;

   assign s_axi_awready = !aw_have_ff && !bvalid_ff;
   assign s_axi_wready = !w_have_ff && !bvalid_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_arready = !rvalid_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;

   // Write path: address and data may arrive in either order.
   always_comb begin
      nxt_aw_have = aw_have_ff;
      nxt_aw_addr = aw_addr_ff;
      nxt_w_have = w_have_ff;
      nxt_w_data = w_data_ff;
      nxt_w_strb = w_strb_ff;
      nxt_bvalid = bvalid_ff;
      nxt_bresp = bresp_ff;
      nxt_ctrl = ctrl_ff;
      nxt_width = width_ff;
      ev_clear = 1'b0;
      do_write = aw_have_ff && w_have_ff && !bvalid_ff;
      if (s_axi_awvalid && s_axi_awready) begin
         nxt_aw_have = 1'b1;
         nxt_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         nxt_w_have = 1'b1;
         nxt_w_data = s_axi_wdata;
         nxt_w_strb = s_axi_wstrb;
      end
      if (do_write) begin
         nxt_aw_have = 1'b0;
         nxt_w_have = 1'b0;
         nxt_bvalid = 1'b1;
         nxt_bresp = pw_trig_pkg::RESP_OKAY;
         if (aw_addr_ff[3:2] == pw_trig_pkg::OFS_CTRL[3:2]) begin
            nxt_ctrl = apply_strb(ctrl_ff, w_data_ff, w_strb_ff);
            nxt_ctrl.spare = '0;
         end else if (aw_addr_ff[3:2] == pw_trig_pkg::OFS_WIDTH[3:2]) begin
            nxt_width = clamp_width(apply_strb(32'(width_ff), w_data_ff,
                                               w_strb_ff));
         end else if (aw_addr_ff[3:2] == pw_trig_pkg::OFS_STATUS[3:2]) begin
            ev_clear = w_strb_ff[0] &&
                       w_data_ff[pw_trig_pkg::STAT_EVENT_BIT];
         end else if (aw_addr_ff[3:2] != pw_trig_pkg::OFS_FREQ[3:2]) begin
            nxt_bresp = pw_trig_pkg::RESP_SLVERR;
         end else begin
            nxt_bresp = pw_trig_pkg::RESP_SLVERR;
         end
      end
      if (bvalid_ff && s_axi_bready) begin
         nxt_bvalid = 1'b0;
      end
      // A new event in the clearing cycle keeps the flag set.
      nxt_event_seen = trig_event_ff || (event_seen_ff && !ev_clear);
   end

   // Read path.
   always_comb begin
      nxt_rvalid = rvalid_ff;
      nxt_rdata = rdata_ff;
      nxt_rresp = rresp_ff;
      if (s_axi_arvalid && s_axi_arready) begin
         nxt_rvalid = 1'b1;
         nxt_rresp = pw_trig_pkg::RESP_OKAY;
         nxt_rdata = 32'h0000_0000;
         if (s_axi_araddr[3:2] == pw_trig_pkg::OFS_CTRL[3:2]) begin
            nxt_rdata = ctrl_ff;
         end else if (s_axi_araddr[3:2] == pw_trig_pkg::OFS_WIDTH[3:2]) begin
            nxt_rdata = 32'(width_ff);
         end else if (s_axi_araddr[3:2] == pw_trig_pkg::OFS_FREQ[3:2]) begin
            nxt_rdata = freq_count;
         end else begin
            nxt_rdata[pw_trig_pkg::STAT_ACTIVE_BIT] = (state_ff !=
                                                       pw_trig_pkg::ST_IDLE);
            nxt_rdata[pw_trig_pkg::STAT_EVENT_BIT] = event_seen_ff;
         end
      end else if (rvalid_ff && s_axi_rready) begin
         nxt_rvalid = 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         aw_have_ff <= 1'b0;
         aw_addr_ff <= 4'h0;
         w_have_ff <= 1'b0;
         w_data_ff <= 32'h0000_0000;
         w_strb_ff <= 4'h0;
         bvalid_ff <= 1'b0;
         bresp_ff <= pw_trig_pkg::RESP_OKAY;
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= pw_trig_pkg::RESP_OKAY;
         ctrl_ff <= pw_trig_pkg::RST_CTRL;
         width_ff <= pw_trig_pkg::RST_WIDTH;
         event_seen_ff <= 1'b0;
      end else begin
         aw_have_ff <= nxt_aw_have;
         aw_addr_ff <= nxt_aw_addr;
         w_have_ff <= nxt_w_have;
         w_data_ff <= nxt_w_data;
         w_strb_ff <= nxt_w_strb;
         bvalid_ff <= nxt_bvalid;
         bresp_ff <= nxt_bresp;
         rvalid_ff <= nxt_rvalid;
         rdata_ff <= nxt_rdata;
         rresp_ff <= nxt_rresp;
         ctrl_ff <= nxt_ctrl;
         width_ff <= nxt_width;
         event_seen_ff <= nxt_event_seen;
      end
   end

   // Tolerance band. At this clock rate the guard figures round to one
   // cycle, so the band is coarser than the analog ideal.
   always_comb begin
      tol_lo = width_ff / WW'(pw_trig_pkg::RES_DIVISOR);
      if (tol_lo < WW'(pw_trig_pkg::GUARD_LO_CYC)) begin
         tol_lo = WW'(pw_trig_pkg::GUARD_LO_CYC);
      end
      tol_hi = tol_lo;
      if (ctrl_ff.cmp_mode == pw_trig_pkg::CMP_NOT_EQUAL &&
          width_ff > WW'(pw_trig_pkg::NE_BAND_LO_CYC) &&
          width_ff <= WW'(pw_trig_pkg::NE_BAND_HI_CYC) &&
          tol_hi < WW'(pw_trig_pkg::GUARD_HI_CYC)) begin
         tol_hi = WW'(pw_trig_pkg::GUARD_HI_CYC);
      end
      lo_limit = (width_ff > tol_lo) ? width_ff - tol_lo : '0;
      hi_limit = width_ff + tol_hi;
   end

   // Measurement and qualification.
   always_comb begin
      active = trig_src ^ ctrl_ff.neg_pol;
      lead_edge = active && !prev_ff;
      trail_edge = !active && prev_ff;
      nxt_state = state_ff;
      nxt_count = count_ff;
      nxt_trig_event = 1'b0;
      nxt_edge_event = (ctrl_ff.trig_type == pw_trig_pkg::TRIG_EDGE) &&
                       lead_edge;
      case (state_ff)
         pw_trig_pkg::ST_IDLE: begin
            if (lead_edge) begin
               nxt_count = WW'(1);
               nxt_state = pw_trig_pkg::ST_PULSE;
            end
         end
         pw_trig_pkg::ST_PULSE: begin
            if (trail_edge) begin
               nxt_state = pw_trig_pkg::ST_IDLE;
               case (ctrl_ff.cmp_mode)
                  pw_trig_pkg::CMP_LESS:
                     nxt_trig_event = count_ff < width_ff;
                  pw_trig_pkg::CMP_EQUAL:
                     nxt_trig_event = count_ff >= lo_limit &&
                                      count_ff <= hi_limit;
                  pw_trig_pkg::CMP_NOT_EQUAL:
                     nxt_trig_event = count_ff < lo_limit;
                  default:
                     nxt_trig_event = 1'b0;
               endcase
            end else begin
               if (~&count_ff) begin
                  nxt_count = count_ff + 1'b1;
               end
               if (ctrl_ff.cmp_mode == pw_trig_pkg::CMP_GREATER &&
                   count_ff >= width_ff) begin
                  nxt_trig_event = 1'b1;
                  nxt_state = pw_trig_pkg::ST_FIRED;
               end else if (ctrl_ff.cmp_mode == pw_trig_pkg::CMP_NOT_EQUAL &&
                            count_ff >= hi_limit) begin
                  nxt_trig_event = 1'b1;
                  nxt_state = pw_trig_pkg::ST_FIRED;
               end
            end
         end
         pw_trig_pkg::ST_FIRED: begin
            // One event per pulse; wait for the pulse to end.
            if (trail_edge) begin
               nxt_state = pw_trig_pkg::ST_IDLE;
            end
         end
         default: begin
            nxt_state = pw_trig_pkg::ST_IDLE;
         end
      endcase
      if (ctrl_ff.trig_type != pw_trig_pkg::TRIG_PULSE) begin
         nxt_trig_event = nxt_edge_event;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         state_ff <= pw_trig_pkg::ST_IDLE;
         count_ff <= '0;
         prev_ff <= 1'b0;
         trig_event_ff <= 1'b0;
         edge_event_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         count_ff <= nxt_count;
         prev_ff <= active;
         trig_event_ff <= nxt_trig_event;
         edge_event_ff <= nxt_edge_event;
      end
   end

   // The counter ignores run state and only stops in video mode.
   assign count_enable = ctrl_ff.trig_type != pw_trig_pkg::TRIG_VIDEO;
   assign count_event = (ctrl_ff.trig_type == pw_trig_pkg::TRIG_PULSE) ?
                        trig_event_ff : edge_event_ff;

   gate_counter #(
      .GATE_CYCLES(GATE_CYCLES),
      .COUNT_W(32)
   ) u_gate (
      .clock(clock),
      .reset(reset),
      .enable(count_enable),
      .event_pulse(count_event),
      .result_ff(freq_count),
      .gate_done_ff()
   );

endmodule

// file: verif/trig_source_model.sv
// Behavioural model of the threshold comparator that feeds the trigger.
// Assumes the bench asks for one pulse at a time and holds go to repeat.
`timescale 1ns/1ps
module trig_source_model (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Pulse request
   input wire logic go,
   input wire logic [7:0] act_len,
   input wire logic [7:0] gap_len,
   input wire logic idle_level,
   output logic busy,
   // Comparator output
   output logic trig_src
);
   logic [8:0] cnt_ff;
   logic [8:0] nxt_cnt;
   // A pulse is act_len active cycles followed by gap_len idle ones.
   always_comb begin
      nxt_cnt = (cnt_ff != 9'h000) ? cnt_ff - 9'h001 : 9'h000;
      if (cnt_ff == 9'h000 && go) nxt_cnt = {1'b0, act_len} + {1'b0, gap_len};
   end
   always_ff @(posedge clock) begin
      if (reset) cnt_ff <= 9'h000;
      else cnt_ff <= nxt_cnt;
   end
   assign busy = cnt_ff != 9'h000;
   // The line rests at idle_level and shows its inverse during a pulse.
   assign trig_src = idle_level ^ (cnt_ff > {1'b0, gap_len});
endmodule

// file: verif/pw_trig_sva.sv
// Checker for the pulse width trigger qualifier, bound to its top module.
// Assumes the bus master offers write address and write data together.
`timescale 1ns/1ps
module pw_trig_sva (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Trigger
   input wire logic trig_src,
   input wire logic trig_event_ff,
   // Write channels
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_bvalid,
   // Read channels
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata
);
   logic take, active, pw, take_ff, full_ff;
   logic [1:0] sel_ff;
   logic [31:0] data_ff;
   logic [4:0] ctrl_ff, nxt_ctrl;
   logic [26:0] width_ff, nxt_width, run_ff, nxt_run;
   assign take = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
   assign active = trig_src ^ ctrl_ff[2];
   assign pw = ctrl_ff[1:0] == pw_trig_pkg::TRIG_PULSE;
   // Shadows mirror full-word writes at the edge the block performs them.
   always_comb begin
      nxt_ctrl = ctrl_ff;
      nxt_width = width_ff;
      if (take_ff && full_ff && sel_ff == 2'h0) nxt_ctrl = data_ff[4:0];
      if (take_ff && full_ff && sel_ff == 2'h1) nxt_width = data_ff[26:0];
      nxt_run = active ? run_ff + 27'h1 : 27'h0;
   end
   always_ff @(posedge clock) begin
      if (reset) begin
         take_ff <= 1'b0;
         ctrl_ff <= 5'h00;
         width_ff <= 27'h1;
         run_ff <= 27'h0;
      end else begin
         take_ff <= take;
         ctrl_ff <= nxt_ctrl;
         width_ff <= nxt_width;
         run_ff <= nxt_run;
      end
      full_ff <= &s_axi_wstrb;
      sel_ff <= s_axi_awaddr[3:2];
      data_ff <= s_axi_wdata;
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);

   AST_RESET_IDLE: assert property ($fell(reset) |->
      !trig_event_ff && !s_axi_bvalid && !s_axi_rvalid)
      else $error("outputs active right after reset");
   AST_EVT_ONE_CYCLE: assert property (trig_event_ff |=> !trig_event_ff)
      else $error("trigger event longer than one cycle");
   AST_READ_LATENCY: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid) else $error("read data late");
   AST_READ_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
   AST_WRITE_LATENCY: assert property (take |=> !s_axi_bvalid ##1
      s_axi_bvalid) else $error("write response off time");
   AST_EDGE_EVENT: assert property (
      ctrl_ff[1:0] == pw_trig_pkg::TRIG_EDGE && $rose(active) |->
      ##1 trig_event_ff) else $error("edge gave no event");
   AST_VIDEO_QUIET: assert property (
      ctrl_ff[1:0] == pw_trig_pkg::TRIG_VIDEO |=> !trig_event_ff)
      else $error("event in video mode");
   AST_LESS_TRAIL: assert property (
      pw && ctrl_ff[4:3] == pw_trig_pkg::CMP_LESS && $fell(active) &&
      run_ff < width_ff |-> ##1 trig_event_ff)
      else $error("short pulse missed");
   AST_GREATER_OUT: assert property (
      pw && ctrl_ff[4:3] == pw_trig_pkg::CMP_GREATER && active &&
      run_ff == width_ff |-> ##1 trig_event_ff)
      else $error("time-out missed");
   AST_EQUAL_TRAIL: assert property (
      pw && ctrl_ff[4:3] == pw_trig_pkg::CMP_EQUAL && $fell(active) &&
      run_ff == width_ff |-> ##1 trig_event_ff)
      else $error("matching pulse missed");
   AST_NE_SHORT: assert property (
      pw && ctrl_ff[4:3] == pw_trig_pkg::CMP_NOT_EQUAL && $fell(active) &&
      run_ff + 27'h1 < width_ff |-> ##1 trig_event_ff)
      else $error("narrow pulse missed");
endmodule

bind pulse_width_trigger pw_trig_sva sva_inst (
   .clock(clock), .reset(reset), .trig_src(trig_src),
   .trig_event_ff(trig_event_ff), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata)
);

// file: verif/testbench.sv
// Self-checking bench for the pulse width trigger qualifier.
// Assumes the comparator model and the checker are compiled beforehand.
`timescale 1ns/1ps
module testbench;
   localparam int MAXW = 64;
   localparam int GATE = 200;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, trig_src, trig_event_ff, busy;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [31:0] s_axi_rdata;
   logic go = 1'b0, idle_level = 1'b0;
   logic [7:0] act_len = 8'h01, gap_len = 8'h02;
   int miscompares = 0, total_checks = 0, ev_cnt = 0, cycles = 0, seed;

   trig_source_model source (.clock(clock), .reset(reset), .go(go),
      .act_len(act_len), .gap_len(gap_len), .idle_level(idle_level),
      .busy(busy), .trig_src(trig_src));
   pulse_width_trigger #(.MAX_WIDTH_CYCLES(MAXW), .GATE_CYCLES(GATE)) DUT (
      .clock(clock), .reset(reset), .trig_src(trig_src),
      .trig_event_ff(trig_event_ff), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp));

   always #50 clock = ~clock;
   always @(posedge clock) begin
      if (trig_event_ff === 1'b1) ev_cnt++;
      cycles++;
      if (cycles == 30000) begin
         miscompares++;
         test_done();
      end
   end

   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clock);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clock);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      check($sformatf("register %h", a), s_axi_rdata, exp);
      check("rresp", 32'(s_axi_rresp), 32'(pw_trig_pkg::RESP_OKAY));
   endtask

   function automatic logic [31:0] fires(input logic [1:0] c, input int n,
                                         input int w);
      case (c)
         pw_trig_pkg::CMP_LESS: fires = 32'(n < w);
         pw_trig_pkg::CMP_GREATER: fires = 32'(n > w);
         pw_trig_pkg::CMP_EQUAL: fires = 32'(n >= w - 1 && n <= w + 1);
         default: fires = 32'(n < w - 1 || n > w + 1);
      endcase
   endfunction

   task automatic pulse(input int n, input logic [31:0] exp);
      int base;
      repeat (4) @(posedge clock);
      base = ev_cnt;
      act_len <= n[7:0];
      go <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
      do @(negedge clock); while (busy);
      repeat (3) @(posedge clock);
      check("event count", ev_cnt - base, exp);
   endtask

   initial begin
      int w, n;
      int lens [4];
      seed = 32'h53aee06d;
      repeat (8) @(posedge clock);
      reset <= 1'b0;
      rd_chk(pw_trig_pkg::OFS_CTRL, pw_trig_pkg::RST_CTRL);
      rd_chk(pw_trig_pkg::OFS_WIDTH, {5'h00, pw_trig_pkg::RST_WIDTH});
      rd_chk(pw_trig_pkg::OFS_STATUS, 32'h0);
      wr(pw_trig_pkg::OFS_WIDTH, 32'h0, 4'hF);
      rd_chk(pw_trig_pkg::OFS_WIDTH, 32'h1);
      wr(pw_trig_pkg::OFS_WIDTH, 32'h12345678, 4'h1);
      rd_chk(pw_trig_pkg::OFS_WIDTH, 32'(MAXW));
      wr(pw_trig_pkg::OFS_FREQ, 32'h1, 4'hF);
      check("freq write response", 32'(rsp), 32'(pw_trig_pkg::RESP_SLVERR));
      wr(pw_trig_pkg::OFS_CTRL, 32'hFFFFFFFF, 4'hF);
      rd_chk(pw_trig_pkg::OFS_CTRL, 32'h1F);
      $display("test registers done");
      for (int p = 0; p < 2; p++) begin
         idle_level <= p[0];
         repeat (70) @(posedge clock);
         for (int c = 0; c < 4; c++) begin
            w = 6 + ($unsigned($random(seed)) % 35);
            wr(pw_trig_pkg::OFS_WIDTH, 32'(w), 4'hF);
            wr(pw_trig_pkg::OFS_CTRL,
               32'({c[1:0], p[0], pw_trig_pkg::TRIG_PULSE}), 4'hF);
            lens = '{1, w - 1, w, w + 5};
            for (int k = 0; k < 5; k++) begin
               n = (k < 4) ? lens[k] : 1 + ($unsigned($random(seed)) % 60);
               if (n != w + 1 && (n != w || c == 2))
                  pulse(n, fires(c[1:0], n, w));
            end
         end
      end
      $display("test pulse width modes done");
      for (int p = 1; p >= 0; p--) begin
         idle_level <= p[0];
         repeat (70) @(posedge clock);
         wr(pw_trig_pkg::OFS_CTRL, 32'({p[0], pw_trig_pkg::TRIG_EDGE}), 4'hF);
         pulse(1, 32'h1);
         pulse(4, 32'h1);
      end
      rd_chk(pw_trig_pkg::OFS_STATUS, 32'h2);
      wr(pw_trig_pkg::OFS_STATUS, 32'h2, 4'h1);
      rd_chk(pw_trig_pkg::OFS_STATUS, 32'h0);
      $display("test edge mode and status done");
      act_len <= 8'h02;
      go <= 1'b1;
      repeat (3 * GATE) @(posedge clock);
      rd_chk(pw_trig_pkg::OFS_FREQ, 32'(GATE / 5));
      go <= 1'b0;
      repeat (10) @(posedge clock);
      wr(pw_trig_pkg::OFS_WIDTH, 32'h0000000A, 4'hF);
      wr(pw_trig_pkg::OFS_CTRL, 32'h00000001, 4'hF);
      go <= 1'b1;
      repeat (3 * GATE) @(posedge clock);
      rd_chk(pw_trig_pkg::OFS_FREQ, 32'(GATE / 5));
      wr(pw_trig_pkg::OFS_CTRL, 32'h00000002, 4'hF);
      repeat (3 * GATE) @(posedge clock);
      rd_chk(pw_trig_pkg::OFS_FREQ, 32'h0);
      go <= 1'b0;
      pulse(5, 32'h0);
      $display("test frequency counter done");
      test_done();
   end
endmodule
